/* verilog/capsense_map.svh */
// Function
// - Continuous conversion works either on one fixed channel or with automatic channel scanning.
// - In continuous mode conversions start once the run flag is set and then keep going.
// - A conversion-complete interrupt is raised only while the enable at bit 0 is set.
// - The capacitance is found by successive approximation, one bit per step from the top.
// - The length select gives 12, 13, 14 or 16 bits, 13 after reset; shorter is faster.
// - Result bits below the selected length read as zero; with accumulation the sum shifted right can leave them set.
// - With accumulation, completion is flagged only after the last conversion of the set.
// - Bits 5:4 add 0, 0.75 us, 1.5 us or 2.25 us to the secondary reset; reset value 00.
// - Lower gain lowers the charge current and lengthens each conversion step.
// - Bits 7:6 and 3 of the reset and gain register read as zero and ignore writes.
`ifndef CAPSENSE_MAP_SVH
`define CAPSENSE_MAP_SVH

// register offsets
`define CS_CONFIG_ADDR     8'ha8
`define CS_MODE2_ADDR      8'ha9
`define CS_RESULT_LO_ADDR  8'haa
`define CS_RESULT_HI_ADDR  8'hab
`define CS_CHANNEL_ADDR    8'hac
`define CS_RST_GAIN_ADDR   8'had
`define CS_IRQ_EN_ADDR     8'hae
`define CS_STATUS_ADDR     8'haf

// config register fields
`define CS_RUN_BIT         7
`define CS_SCAN_BIT        3
`define CS_CONT_BIT        2
`define CS_ACC_LSB         0
`define CS_CONFIG_RST      8'h00

// mode2, reset/gain, enable, status fields
`define CS_LEN_LSB         0
`define CS_LEN_RST         2'h1
`define CS_EXT_LSB         4
`define CS_GAIN_LSB        0
`define CS_RST_GAIN_RST    8'h07
`define CS_RST_GAIN_MASK   8'h37
`define CS_DONE_BIT        0
`define CS_IRQ_EN_RST      8'h00

// timing
`define CS_CLK_MHZ         250
`define CS_EXT_STEP_NS     750
`define CS_EXT_STEP_CYC    ((`CS_EXT_STEP_NS * `CS_CLK_MHZ + 999) / 1000)
`define CS_RST1_NS         128
`define CS_RST1_CYC        ((`CS_RST1_NS * `CS_CLK_MHZ + 999) / 1000)
`define CS_RST2_NS         64
`define CS_RST2_CYC        ((`CS_RST2_NS * `CS_CLK_MHZ + 999) / 1000)
`define CS_CHG_NS          64
`define CS_CHG_CYC         ((`CS_CHG_NS * `CS_CLK_MHZ + 999) / 1000)

`endif

/* verilog/capsense_pkg.sv */
package capsense_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RST1,
        ST_RST2,
        ST_CHARGE,
        ST_WAIT_BIT,
        ST_FINISH
    } conv_state_t;

endpackage

/* verilog/capsense_phase_timer.sv */
`timescale 1ns/1ps
module capsense_phase_timer #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    // control
    input  wire logic         load_in,
    input  wire logic [W-1:0] count_in,
    // status
    output logic              done_out
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         done_d;

    // done pulses in the same cycle the count runs out to zero; a count of 0 never ends
    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (load_in) begin
            cnt_d = count_in;
        end else if (cnt_q != '0) begin
            cnt_d  = cnt_q - 1'b1;
            done_d = (cnt_q == {{(W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_q    <= '0;
            done_out <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            done_out <= done_d;
        end
    end

endmodule

/* verilog/capsense_sar_core.sv */
`timescale 1ns/1ps
module capsense_sar_core #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    // sequencing
    input  wire logic         start_in,
    input  wire logic         step_in,
    input  wire logic         comp_in,
    input  wire logic [4:0]   nbits_in,
    // results
    output logic [W-1:0]      code_out,
    output logic              last_out
);

    logic [W-1:0] code_d;
    logic [W-1:0] bit_q;
    logic [W-1:0] bit_d;
    logic [W-1:0] stop_q;
    logic [W-1:0] stop_d;
    logic         last_d;

    always_comb begin
        code_d = code_out;
        bit_d  = bit_q;
        stop_d = stop_q;
        last_d = 1'b0;
        if (start_in) begin
            // trial starts at the top bit; lower bits stay 0 until reached
            bit_d  = {1'b1, {(W-1){1'b0}}};
            code_d = {1'b1, {(W-1){1'b0}}};
            stop_d = {{(W-1){1'b0}}, 1'b1} << (W[4:0] - nbits_in);
        end else if (step_in && bit_q != '0) begin
            if (!comp_in) begin
                code_d = code_out & ~bit_q;
            end
            if (bit_q == stop_q) begin
                // unconverted bits were never set, so they read 0
                bit_d  = '0;
                last_d = 1'b1;
            end else begin
                bit_d  = bit_q >> 1;
                code_d = code_d | (bit_q >> 1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            code_out <= '0;
            bit_q    <= '0;
            stop_q   <= '0;
            last_out <= 1'b0;
        end else begin
            code_out <= code_d;
            bit_q    <= bit_d;
            stop_q   <= stop_d;
            last_out <= last_d;
        end
    end

endmodule

/* verilog/capacitive_sense_conversion_ctrl.sv */
`timescale 1ns/1ps
`include "capsense_map.svh"
module capacitive_sense_conversion_ctrl #(
    parameter int W        = 16,
    parameter int CHANNELS = 16,
    parameter int TW       = 12
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    // register port
    input  wire logic [7:0]   addr_in,
    input  wire logic [7:0]   wdata_in,
    input  wire logic         wr_in,
    input  wire logic         rd_in,
    output logic [7:0]        rdata_out,
    // interrupt
    output logic              irq_out,
    // analogue front end
    input  wire logic         comp_in,
    output logic              elec_reset_out,
    output logic              second_reset_out,
    output logic              charge_en_out,
    output logic [2:0]        gain_out,
    output logic [W-1:0]      trial_code_out,
    output logic [3:0]        chan_sel_out
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and state

    capsense_pkg::conv_state_t state_q;
    capsense_pkg::conv_state_t state_d;

    logic [7:0]   config_q;
    logic [7:0]   config_d;
    logic [1:0]   len_q;
    logic [1:0]   len_d;
    logic [7:0]   rst_gain_q;
    logic [7:0]   rst_gain_d;
    logic         irq_en_q;
    logic         irq_en_d;
    logic         done_flag_q;
    logic         done_flag_d;
    logic [3:0]   chan_q;
    logic [3:0]   chan_d;
    logic [W-1:0] result_q;
    logic [W-1:0] result_d;
    logic [W+3:0] accum_q;
    logic [W+3:0] accum_d;
    logic [3:0]   acc_left_q;
    logic [3:0]   acc_left_d;
    logic [7:0]   rdata_d;
    logic         irq_d;
    logic         elec_reset_d;
    logic         second_reset_d;
    logic         charge_en_d;

    // front-end controls
    logic          timer_load;
    logic [TW-1:0] timer_count;
    logic          timer_done;
    logic          sar_start;
    logic          sar_step;
    logic [W-1:0]  sar_code;
    logic          sar_last;
    logic [4:0]    nbits;
    logic [1:0]    ext_sel;
    logic [2:0]    gain_sel;
    logic [3:0]    acc_total;

    logic run_flag;
    logic cont_mode;
    logic scan_en;
    logic wr_config;
    logic set_done;

    assign run_flag  = config_q[`CS_RUN_BIT];
    assign cont_mode = config_q[`CS_CONT_BIT];
    assign scan_en   = config_q[`CS_SCAN_BIT];
    assign ext_sel   = rst_gain_q[`CS_EXT_LSB +: 2];
    assign gain_sel  = rst_gain_q[`CS_GAIN_LSB +: 3];
    assign wr_config = wr_in && (addr_in == `CS_CONFIG_ADDR);
    assign acc_total = 4'h1 << config_q[`CS_ACC_LSB +: 2];

    // length select 00/01/10/11 gives 12/13/14/16 bits
    always_comb begin
        case (len_q)
            2'h0:    nbits = 5'h0c;
            2'h1:    nbits = 5'h0d;
            2'h2:    nbits = 5'h0e;
            default: nbits = 5'h10;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion sequencer

    capsense_phase_timer #(
        .W (TW)
    ) u_timer (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .load_in  (timer_load),
        .count_in (timer_count),
        .done_out (timer_done)
    );

    capsense_sar_core #(
        .W (W)
    ) u_sar (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .start_in (sar_start),
        .step_in  (sar_step),
        .comp_in  (comp_in),
        .nbits_in (nbits),
        .code_out (sar_code),
        .last_out (sar_last)
    );

    always_comb begin
        state_d     = state_q;
        timer_load  = 1'b0;
        timer_count = '0;
        sar_start   = 1'b0;
        sar_step    = 1'b0;
        set_done    = 1'b0;
        accum_d     = accum_q;
        acc_left_d  = acc_left_q;
        result_d    = result_q;
        chan_d      = chan_q;
        case (state_q)
            capsense_pkg::ST_IDLE: begin
                // conversions begin only once the run flag is set
                if (run_flag) begin
                    state_d     = capsense_pkg::ST_RST1;
                    timer_load  = 1'b1;
                    timer_count = TW'(`CS_RST1_CYC);
                    accum_d     = '0;
                    acc_left_d  = acc_total;
                end
            end
            capsense_pkg::ST_RST1: begin
                if (timer_done) begin
                    state_d     = capsense_pkg::ST_RST2;
                    timer_load  = 1'b1;
                    timer_count = TW'(`CS_RST2_CYC + ext_sel * `CS_EXT_STEP_CYC);
                end
            end
            capsense_pkg::ST_RST2: begin
                if (timer_done) begin
                    state_d     = capsense_pkg::ST_CHARGE;
                    timer_load  = 1'b1;
                    // lower gain means less current, so each step charges longer
                    timer_count = TW'(`CS_CHG_CYC * (8 - gain_sel));
                    sar_start   = 1'b1;
                end
            end
            capsense_pkg::ST_CHARGE: begin
                if (timer_done) begin
                    state_d  = capsense_pkg::ST_WAIT_BIT;
                    sar_step = 1'b1;
                end
            end
            capsense_pkg::ST_WAIT_BIT: begin
                if (sar_last) begin
                    state_d = capsense_pkg::ST_FINISH;
                    accum_d = accum_q + (W+4)'(sar_code);
                end else begin
                    state_d     = capsense_pkg::ST_CHARGE;
                    timer_load  = 1'b1;
                    timer_count = TW'(`CS_CHG_CYC * (8 - gain_sel));
                end
            end
            capsense_pkg::ST_FINISH: begin
                if (acc_left_q > 4'h1) begin
                    // more conversions in the set: no completion yet
                    acc_left_d  = acc_left_q - 4'h1;
                    state_d     = capsense_pkg::ST_RST1;
                    timer_load  = 1'b1;
                    timer_count = TW'(`CS_RST1_CYC);
                end else begin
                    result_d = W'(accum_q >> config_q[`CS_ACC_LSB +: 2]);
                    set_done = 1'b1;
                    state_d  = capsense_pkg::ST_IDLE;
                    if (cont_mode && scan_en) begin
                        chan_d = (chan_q == 4'(CHANNELS - 1)) ? 4'h0 : chan_q + 4'h1;
                    end
                end
            end
            default: state_d = capsense_pkg::ST_IDLE;
        endcase
        // clearing the run flag abandons a conversion in progress; a finish that
        // lands just after the abort must not post a result or completion
        if (!run_flag) begin
            state_d  = capsense_pkg::ST_IDLE;
            set_done = 1'b0;
            result_d = result_q;
        end
        if (wr_in && addr_in == `CS_CHANNEL_ADDR) begin
            chan_d = wdata_in[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    always_comb begin
        config_d    = config_q;
        len_d       = len_q;
        rst_gain_d  = rst_gain_q;
        irq_en_d    = irq_en_q;
        done_flag_d = done_flag_q;
        if (set_done && !cont_mode) begin
            config_d[`CS_RUN_BIT] = 1'b0;
        end
        if (wr_config) begin
            // a fresh write of 1 wins over the hardware clear
            config_d = wdata_in;
        end
        if (wr_in && addr_in == `CS_MODE2_ADDR) begin
            len_d = wdata_in[`CS_LEN_LSB +: 2];
        end
        if (wr_in && addr_in == `CS_RST_GAIN_ADDR) begin
            rst_gain_d = wdata_in & `CS_RST_GAIN_MASK;
        end
        if (wr_in && addr_in == `CS_IRQ_EN_ADDR) begin
            irq_en_d = wdata_in[`CS_DONE_BIT];
        end
        if (rd_in && addr_in == `CS_STATUS_ADDR) begin
            done_flag_d = 1'b0;
        end
        if (set_done) begin
            done_flag_d = 1'b1;
        end
    end

    // read data; the run flag reads its live value, so a poll one cycle
    // after the setting write already sees it high
    always_comb begin
        rdata_d = 8'h00;
        if (rd_in) begin
            case (addr_in)
                `CS_CONFIG_ADDR:    rdata_d = config_q;
                `CS_MODE2_ADDR:     rdata_d = {6'h00, len_q};
                `CS_RESULT_LO_ADDR: rdata_d = result_q[7:0];
                `CS_RESULT_HI_ADDR: rdata_d = result_q[W-1 -: 8];
                `CS_CHANNEL_ADDR:   rdata_d = {4'h0, chan_q};
                `CS_RST_GAIN_ADDR:  rdata_d = rst_gain_q & `CS_RST_GAIN_MASK;
                `CS_IRQ_EN_ADDR:    rdata_d = {7'h00, irq_en_q};
                `CS_STATUS_ADDR:    rdata_d = {7'h00, done_flag_q};
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    always_comb begin
        irq_d          = done_flag_d && irq_en_d;
        elec_reset_d   = (state_d == capsense_pkg::ST_RST1);
        second_reset_d = (state_d == capsense_pkg::ST_RST2);
        charge_en_d    = (state_d == capsense_pkg::ST_CHARGE);
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q          <= capsense_pkg::ST_IDLE;
            config_q         <= `CS_CONFIG_RST;
            len_q            <= `CS_LEN_RST;
            rst_gain_q       <= `CS_RST_GAIN_RST;
            irq_en_q         <= 1'b0;
            done_flag_q      <= 1'b0;
            chan_q           <= 4'h0;
            result_q         <= '0;
            accum_q          <= '0;
            acc_left_q       <= 4'h0;
            rdata_out        <= 8'h00;
            irq_out          <= 1'b0;
            elec_reset_out   <= 1'b0;
            second_reset_out <= 1'b0;
            charge_en_out    <= 1'b0;
            gain_out         <= 3'(`CS_RST_GAIN_RST);
            chan_sel_out     <= 4'h0;
        end else begin
            state_q          <= state_d;
            config_q         <= config_d;
            len_q            <= len_d;
            rst_gain_q       <= rst_gain_d;
            irq_en_q         <= irq_en_d;
            done_flag_q      <= done_flag_d;
            chan_q           <= chan_d;
            result_q         <= result_d;
            accum_q          <= accum_d;
            acc_left_q       <= acc_left_d;
            rdata_out        <= rdata_d;
            irq_out          <= irq_d;
            elec_reset_out   <= elec_reset_d;
            second_reset_out <= second_reset_d;
            charge_en_out    <= charge_en_d;
            gain_out         <= rst_gain_d[`CS_GAIN_LSB +: 3];
            chan_sel_out     <= chan_d;
        end
    end

    assign trial_code_out = sar_code;

endmodule

/* tb/cs_chk_sva.sv */
`timescale 1ns/1ps
module cs_chk #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic         clk_in,
    input wire logic         reset_in,
    // register port
    input wire logic [7:0]   addr_in,
    input wire logic [7:0]   wdata_in,
    input wire logic         wr_in,
    input wire logic         rd_in,
    input wire logic [7:0]   rdata_out,
    input wire logic         irq_out,
    // front end
    input wire logic         elec_reset_out,
    input wire logic         second_reset_out,
    input wire logic         charge_en_out,
    input wire logic [2:0]   gain_out,
    input wire logic [W-1:0] trial_code_out
);
    logic [1:0] len_q, len_d;
    logic       en_q, en_d, go_q, go_d;
    logic [7:0] cnt_q, cnt_d;
    logic [3:0] lm;
    always_comb begin
        len_d = len_q;
        en_d = en_q;
        go_d = go_q;
        cnt_d = charge_en_out ? cnt_q + 8'h01 : 8'h00;
        if (wr_in && addr_in == 8'ha9) begin
            len_d = wdata_in[1:0];
        end
        if (wr_in && addr_in == 8'hae) begin
            en_d = wdata_in[0];
        end
        // an abort write drops go, so cut-short phases are not judged
        if (wr_in && addr_in == 8'ha8) begin
            go_d = wdata_in[7];
        end
        lm = (len_q == 2'h3) ? 4'h0 : 4'hf >> len_q;
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            len_q <= 2'h1;
            en_q <= 1'b0;
            go_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            len_q <= len_d;
            en_q <= en_d;
            go_q <= go_d;
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////
    property p_unused_zero;
        $past(rd_in) && $past(addr_in) == 8'had |-> rdata_out[7:6] == 2'h0 && !rdata_out[3];
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused reset/gain bits read nonzero");
    property p_gain;
        wr_in && addr_in == 8'had |-> ##2 gain_out == $past(wdata_in[2:0], 2);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain output does not follow write");
    property p_irq_mask;
        irq_out |-> en_q || $past(en_q);
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt while disabled");
    property p_irq_clear;
        rd_in && addr_in == 8'haf |-> ##2 !irq_out;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("interrupt stays after status read");
    property p_start;
        $rose(elec_reset_out) |-> go_q;
    endproperty
    a_start: assert property (p_start)
        else $error("conversion without run flag");
    property p_second;
        $fell(elec_reset_out) && go_q |-> ##[0:2] second_reset_out;
    endproperty
    a_second: assert property (p_second)
        else $error("no secondary reset after primary");
    property p_charge_len;
        $fell(charge_en_out) && go_q |-> cnt_q == 8'd129 - {gain_out, 4'h0};
    endproperty
    a_charge_len: assert property (p_charge_len)
        else $error("charge length wrong for gain");
    property p_low_zero;
        charge_en_out |-> (trial_code_out[3:0] & lm) == 4'h0;
    endproperty
    a_low_zero: assert property (p_low_zero)
        else $error("unconverted trial bit set");
    c_irq: cover property ($rose(irq_out));
    c_charge: cover property ($fell(charge_en_out) && gain_out == 3'h6);
    c_ext: cover property ($fell(second_reset_out) && go_q);
endmodule
bind capacitive_sense_conversion_ctrl cs_chk #(.W(W)) u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .elec_reset_out(elec_reset_out), .second_reset_out(second_reset_out),
    .charge_en_out(charge_en_out), .gain_out(gain_out), .trial_code_out(trial_code_out));

/* tb/cs_electrode.sv */
`timescale 1ns/1ps
module cs_electrode (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // front end
    input  wire logic        charge_en_in,
    input  wire logic [15:0] trial_in,
    input  wire logic [15:0] cap_in,
    output logic             comp_out
);
    logic hold_q, hold_d, junk_q, junk_d;
    always_comb begin
        hold_d = charge_en_in;
        junk_d = ~junk_q;
        // outside charge and compare the comparator means nothing: scramble it
        comp_out = (charge_en_in || hold_q) ? (cap_in >= trial_in) : junk_q;
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hold_q <= 1'b0;
            junk_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            junk_q <= junk_d;
        end
    end
endmodule

/* tb/tb_capacitive_sense_conversion_ctrl.sv */
`timescale 1ns/1ps
module tb_capacitive_sense_conversion_ctrl;
    logic        clk_in, reset_in, wr_in, rd_in, irq_out, comp_in, rd_q;
    logic        elec_reset_out, second_reset_out, charge_en_out;
    logic [7:0]  addr_in, wdata_in, rdata_out;
    logic [2:0]  gain_out, prev_q;
    logic [15:0] trial_code_out, cap_q;
    logic [3:0]  chan_sel_out;
    logic [7:0]  exp_q[$];
    int          chans[$];
    int          miscompares, total_checks, cyc, pulses, npri, sec_cnt, last_sec, s0, early;
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    capacitive_sense_conversion_ctrl i_dut (.clk_in(clk_in), .reset_in(reset_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .irq_out(irq_out), .comp_in(comp_in),
        .elec_reset_out(elec_reset_out), .second_reset_out(second_reset_out),
        .charge_en_out(charge_en_out), .gain_out(gain_out),
        .trial_code_out(trial_code_out), .chan_sel_out(chan_sel_out));
    cs_electrode i_elec (.clk_in(clk_in), .reset_in(reset_in), .charge_en_in(charge_en_out),
        .trial_in(trial_code_out), .cap_in(cap_q), .comp_out(comp_in));
    ////////////////////////////////////////////////////////////
    task automatic cmp_v(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_cnt(string n, int e, int g);
        total_checks++;
        if (g != e) begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic op(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clk_in);
        wr_in <= w;
        rd_in <= !w;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        op(1'b1, a, d);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        exp_q.push_back(e);
        op(1'b0, a, 8'h00);
    endtask
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one conversion set; the masked case enables the interrupt afterwards
    task automatic conv(int len, int acc, logic en);
        int nb;
        logic [15:0] r;
        nb = (len == 3) ? 16 : 12 + len;
        cap_q <= 16'($urandom);
        pulses = 0;
        early = 0;
        wr(8'hae, {7'h0, en});
        wr(8'ha9, 8'(len));
        wr(8'ha8, 8'h80 | 8'(acc));
        rd(8'ha8, 8'h80 | 8'(acc));
        for (int i = 0; i < 20000 && (pulses < nb << acc || charge_en_out); i++) begin
            @(posedge clk_in);
            early += irq_out;
        end
        repeat (8) @(posedge clk_in);
        cmp_cnt("early irq", 0, early);
        cmp_v("irq", {7'h0, en}, {7'h0, irq_out});
        if (!en) begin
            wr(8'hae, 8'h01);
            repeat (2) @(posedge clk_in);
            cmp_v("irq", 8'h01, {7'h0, irq_out});
        end
        cmp_cnt("pulses", nb << acc, pulses);
        rd(8'haf, 8'h01);
        rd(8'ha8, 8'(acc));
        r = cap_q & (16'hffff << (16 - nb));
        rd(8'haa, r[7:0]);
        rd(8'hab, r[15:8]);
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        cyc++;
        rd_q <= rd_in;
        if (rd_q) begin
            cmp_v("rdata", exp_q.pop_front(), rdata_out);
        end
        if (charge_en_out && !prev_q[0]) pulses++;
        if (elec_reset_out && !prev_q[1]) begin
            npri++;
            chans.push_back(int'(chan_sel_out));
        end
        if (second_reset_out) begin
            sec_cnt++;
        end else if (prev_q[2]) begin
            last_sec = sec_cnt;
            sec_cnt = 0;
        end
        prev_q <= {second_reset_out, elec_reset_out, charge_en_out};
        if (cyc > 20000) begin
            miscompares++;
            print_verdict;
        end
    end
    initial begin
        reset_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        cap_q = 16'h0000;
        rd_q = 1'b0;
        prev_q = 3'h0;
        void'($urandom(32'he227));
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(8'had, 8'h07);
        rd(8'ha9, 8'h01);
        rd(8'hb0, 8'h00);
        for (int g = 0; g < 8; g++) begin
            wr(8'had, 8'hc8 | {2'h0, 2'(g), 1'b0, 3'(g)});
            rd(8'had, {2'h0, 2'(g), 1'b0, 3'(g)});
        end
        wr(8'had, 8'h07);
        for (int i = 0; i < 7; i++) conv(i < 4 ? i : 1, i < 4 ? 0 : i - 3, 1'b1);
        s0 = last_sec;
        conv(3, 0, 1'b0);
        wr(8'had, 8'h36);
        conv(2, 0, 1'b1);
        cmp_cnt("ext", s0 + 3 * 188, last_sec);
        wr(8'had, 8'h07);
        for (int s = 0; s < 2; s++) begin
            wr(8'hac, 8'h0e);
            npri = 0;
            chans.delete();
            wr(8'ha8, 8'h84 | 8'(s << 3));
            for (int i = 0; i < 4000 && npri < 3; i++) @(posedge clk_in);
            wr(8'ha8, 8'h00);
            rd(8'haf, 8'h01);
            for (int k = 0; k < 3; k++) cmp_cnt("chan", (14 + s * k) % 16, chans[k]);
        end
        print_verdict;
    end
endmodule
